// File: status_move_consts.svh
// Constants for the floating-point status move unit.
`ifndef STATUS_MOVE_CONSTS_SVH
`define STATUS_MOVE_CONSTS_SVH

// Opcodes.
`define SMV_PRIMARY_FLOAT   6'h3F
`define SMV_XO_READ         10'h247
`define SMV_XO_TO_COND      10'h040
`define SMV_XO_FIELDS       10'h2C7
`define SMV_XO_IMM          10'h086
`define SMV_XO_BIT_SET      10'h026
`define SMV_XO_BIT_CLR      10'h046
`define SMV_XO_ROUND_SINGLE 10'h00C

// Status bit positions, bit 0 being the most significant.
`define SMV_EXC_SUM   0
`define SMV_ENA_SUM   1
`define SMV_INV_SUM   2
`define SMV_OVF       3
`define SMV_UNF       4
`define SMV_ZDIV      5
`define SMV_INEXACT   6
`define SMV_INV_EN    24
`define SMV_OVF_EN    25
`define SMV_UNF_EN    26
`define SMV_ZDIV_EN   27
`define SMV_INEXACT_EN 28

// Bit masks over the status word, reset value and the all-ones high half of the read result.
`define SMV_RESERVED_MASK 32'h0000_0F04
`define SMV_EXC_MASK      32'h1FF8_0000
`define SMV_INV_MASK      32'h01F8_0000
`define SMV_FSC_RESET     32'h0000_0000
`define SMV_QNAN_HIGH     32'hFFFF_FFFF

// Exception clear masks of the copy-to-condition operation, per selector.
`define SMV_CLR_SEL0 4'h9
`define SMV_CLR_SEL1 4'hF
`define SMV_CLR_SEL2 4'hF
`define SMV_CLR_SEL3 4'h8

// Exponent limits of the round-to-single classification.
`define SMV_EXP_UNF_LIMIT 11'h381
`define SMV_EXP_OVF_LOW   11'h47E
`define SMV_EXP_MAX       11'h7FF
`define SMV_EXP_NORM_LOW  11'h380
`define SMV_EXP_NORM_HIGH 11'h47F

// Cycles that floating-point operations are held after a synchronising write.
`define SMV_SYNC_HOLD_CYCLES 4'h2

`endif

// File: status_move_pkg.sv
// Types shared by the floating-point status move unit.
`default_nettype none
package status_move_pkg;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_READ,
    OP_TO_COND,
    OP_FIELDS,
    OP_IMM,
    OP_BIT_SET,
    OP_BIT_CLR,
    OP_ROUND_SINGLE
  } op_t;

  typedef enum logic [3:0] {
    RS_NONE,
    RS_UNDERFLOW_DISABLED,
    RS_UNDERFLOW_ENABLED,
    RS_OVERFLOW_DISABLED,
    RS_OVERFLOW_ENABLED,
    RS_NORMAL,
    RS_ZERO,
    RS_INFINITY,
    RS_QUIET_NAN,
    RS_SIGNALING_NAN
  } rs_path_t;

  typedef struct packed {
    logic        we;
    logic [4:0]  idx;
    logic [0:63] data;
  } fr_write_t;

  typedef struct packed {
    logic        we;
    logic [0:31] data;
  } cr_write_t;

  typedef struct packed {
    logic [0:5] primary;
    logic [0:4] tgt;
    logic [0:2] bf;
    logic [0:2] bfa;
    logic [0:3] imm;
    logic [0:7] mask;
    logic [0:9] xo;
    logic       record;
  } insn_fields_t;

  typedef struct packed {
    logic [0:31] fsc;
    fr_write_t   fr;
    cr_write_t   cr;
    logic        rs_valid;
    rs_path_t    rs_path;
    logic        hold;
    logic [3:0]  hold_cnt;
    logic        done;
    logic        illegal;
  } state_t;

endpackage
`default_nettype wire

// File: field_insert.sv
// Replaces one field of a word made of equal fields.
`default_nettype none
module field_insert #(
  parameter int FW = 4,
  parameter int NF = 8
) (
  // Word and field.
  input  wire logic [0:FW*NF-1]      i_word,
  input  wire logic [$clog2(NF)-1:0] i_idx,
  input  wire logic [0:FW-1]         i_field,
  // Result.
  output logic      [0:FW*NF-1]      o_word
);

  always_comb
  begin
    o_word = i_word;
    o_word[i_idx*FW +: FW] = i_field;
  end

endmodule
`default_nettype wire

// File: round_single_classifier.sv
// Picks the round-to-single path for a double-precision operand.
`default_nettype none
`include "status_move_consts.svh"
module round_single_classifier
  import status_move_pkg::*;
(
  // Operand and enables.
  input  wire logic [0:63] i_operand,
  input  wire logic        i_underflow_enable,
  input  wire logic        i_overflow_enable,
  // Chosen path.
  output rs_path_t         o_path
);

  logic [0:10] exp;
  logic [0:51] frac;
  logic        mag_zero;

  assign exp      = i_operand[1:11];
  assign frac     = i_operand[12:63];
  assign mag_zero = (i_operand[1:63] == 63'h0);

  always_comb
  begin
    if (exp < `SMV_EXP_UNF_LIMIT && !mag_zero)
    begin
      o_path = i_underflow_enable ? RS_UNDERFLOW_ENABLED : RS_UNDERFLOW_DISABLED; // RULE15
    end
    else if (exp > `SMV_EXP_OVF_LOW && exp < `SMV_EXP_MAX)
    begin
      o_path = i_overflow_enable ? RS_OVERFLOW_ENABLED : RS_OVERFLOW_DISABLED; // RULE16
    end
    else if (exp > `SMV_EXP_NORM_LOW && exp < `SMV_EXP_NORM_HIGH)
    begin
      o_path = RS_NORMAL; // RULE17
    end
    else if (mag_zero)
    begin
      o_path = RS_ZERO; // RULE18
    end
    else if (frac == 52'h0)
    begin
      o_path = RS_INFINITY; // RULE19
    end
    else if (frac[0])
    begin
      o_path = RS_QUIET_NAN; // RULE19
    end
    else
    begin
      o_path = RS_SIGNALING_NAN; // RULE19
    end
  end

endmodule
`default_nettype wire

// File: fp_status_move_unit.sv
// Execution unit for floating-point status moves and round-to-single classification.
//
// Behaviour
// RULE1 - Status read copies status into low half
// RULE2 - Status read fills high half with ones
// RULE3 - Record flag copies four summaries to field one
// RULE4 - Selected status field copied to chosen condition field
// RULE5 - Reserved status bits copy as zero
// RULE6 - Copied field's exception bits cleared per selector
// RULE7 - Field one undefined when recording elsewhere
// RULE8 - Masked write of operand low half into status
// RULE9 - Status writes hold off later float operations
// RULE10 - Enabled and invalid summaries always derived
// RULE11 - Field zero write sets summary, overflow explicitly
// RULE12 - Immediate nibble written into selected status field
// RULE13 - Bit set operation sets indexed status bit
// RULE14 - Bit clear operation clears indexed status bit
// RULE15 - Small nonzero exponent takes underflow path
// RULE16 - Large finite exponent takes overflow path
// RULE17 - Exponent in range takes normal path
// RULE18 - Signed zero takes zero path
// RULE19 - All-ones exponent classified by fraction
// RULE20 - Status bit zero is most significant
`default_nettype none
`include "status_move_consts.svh"
module fp_status_move_unit
  import status_move_pkg::*;
#(
  parameter logic [3:0] SYNC_HOLD = `SMV_SYNC_HOLD_CYCLES,
  parameter logic [9:0] RS_XO     = `SMV_XO_ROUND_SINGLE
) (
  // Clock and reset.
  input  wire logic        I_MCLK,
  input  wire logic        I_RESET_N,
  // Issued instruction and its operands.
  input  wire logic        I_INSN_VALID,
  input  wire logic [0:31] I_INSN,
  input  wire logic [0:63] I_OPERAND_B,
  input  wire logic [0:31] I_COND_REG,
  // Issue handshake.
  output logic             O_READY,
  output logic             O_FP_HOLD,
  output logic             O_DONE,
  output logic             O_ILLEGAL,
  // Results.
  output fr_write_t        O_FR_WRITE,
  output cr_write_t        O_CR_WRITE,
  output logic [0:31]      O_FLOAT_STATUS_CONTROL,
  output logic             O_RS_VALID,
  output rs_path_t         O_RS_PATH
);

  state_t       st_q;
  state_t       st_d;
  insn_fields_t f;
  op_t          op;
  logic         accept;
  logic [0:3]   sel_field;
  logic [0:3]   clr_mask;
  logic [0:31]  imm_word;
  logic [0:31]  cr_copy;
  logic [0:31]  operand_low;
  rs_path_t     rs_path;

  // Field extraction, bit 0 being the most significant bit of the word.
  assign f.primary = I_INSN[0:5];
  assign f.tgt     = I_INSN[6:10];
  assign f.bf      = I_INSN[6:8];
  assign f.bfa     = I_INSN[11:13];
  assign f.imm     = I_INSN[16:19];
  assign f.mask    = I_INSN[7:14];
  assign f.xo      = I_INSN[21:30];
  assign f.record  = I_INSN[31];

  assign operand_low = I_OPERAND_B[32:63];
  assign accept      = I_INSN_VALID && !st_q.hold;

  always_comb
  begin
    op = OP_NONE;
    if (f.primary == `SMV_PRIMARY_FLOAT)
    begin
      if (f.xo == `SMV_XO_READ)
      begin
        op = OP_READ;
      end
      else if (f.xo == `SMV_XO_TO_COND)
      begin
        op = OP_TO_COND;
      end
      else if (f.xo == `SMV_XO_FIELDS)
      begin
        op = OP_FIELDS;
      end
      else if (f.xo == `SMV_XO_IMM)
      begin
        op = OP_IMM;
      end
      else if (f.xo == `SMV_XO_BIT_SET)
      begin
        op = OP_BIT_SET;
      end
      else if (f.xo == `SMV_XO_BIT_CLR)
      begin
        op = OP_BIT_CLR;
      end
      else if (f.xo == RS_XO)
      begin
        op = OP_ROUND_SINGLE;
      end
    end
  end

  // The status word never holds reserved bits, and they are masked again on the way out.
  assign sel_field = st_q.fsc[{f.bfa, 2'b00} +: 4] & ~4'(`SMV_RESERVED_MASK >> (5'd28 - {f.bfa, 2'b00})); // RULE5

  always_comb
  begin
    case (f.bfa)
      3'h0:    clr_mask = `SMV_CLR_SEL0;
      3'h1:    clr_mask = `SMV_CLR_SEL1;
      3'h2:    clr_mask = `SMV_CLR_SEL2;
      3'h3:    clr_mask = `SMV_CLR_SEL3;
      default: clr_mask = 4'h0;
    endcase
  end

  field_insert #(
    .FW (4),
    .NF (8)
  ) u_cond_insert (
    .i_word  (I_COND_REG),
    .i_idx   (f.bf),
    .i_field (sel_field),
    .o_word  (cr_copy)
  ); // RULE4

  field_insert #(
    .FW (4),
    .NF (8)
  ) u_imm_insert (
    .i_word  (st_q.fsc),
    .i_idx   (f.bf),
    .i_field (f.imm),
    .o_word  (imm_word)
  ); // RULE12

  round_single_classifier u_classifier (
    .i_operand          (I_OPERAND_B),
    .i_underflow_enable (st_q.fsc[`SMV_UNF_EN]),
    .i_overflow_enable  (st_q.fsc[`SMV_OVF_EN]),
    .o_path             (rs_path)
  );

  always_comb
  begin
    logic [0:31] nxt;
    logic [0:31] cr_new;
    logic        fx_explicit;
    logic        sync_op;
    logic        vx;
    logic        enabled_exception_summary;
    nxt         = st_q.fsc;
    cr_new      = I_COND_REG;
    fx_explicit = 1'b0;
    sync_op     = 1'b0;
    vx          = 1'b0;
    enabled_exception_summary         = 1'b0;
    st_d          = st_q;
    st_d.fr.we    = 1'b0;
    st_d.cr.we    = 1'b0;
    st_d.rs_valid = 1'b0;
    st_d.done     = 1'b0;
    st_d.illegal  = 1'b0;
    if (st_q.hold_cnt != 4'h0)
    begin
      st_d.hold_cnt = st_q.hold_cnt - 4'h1;
    end
    if (accept)
    begin
      st_d.done = (op != OP_NONE);
      st_d.illegal = (op == OP_NONE);
      case (op)
        OP_READ:
        begin
          st_d.fr.we   = 1'b1;
          st_d.fr.idx  = f.tgt;
          st_d.fr.data = {`SMV_QNAN_HIGH, st_q.fsc}; // RULE1 RULE2
        end
        OP_TO_COND:
        begin
          cr_new = cr_copy; // RULE4
          nxt[{f.bfa, 2'b00} +: 4] = st_q.fsc[{f.bfa, 2'b00} +: 4] & ~clr_mask; // RULE6
          fx_explicit = 1'b1;
        end
        OP_FIELDS:
        begin
          sync_op = 1'b1;
          for (int n = 0; n < 8; n++)
          begin
            if (f.mask[n])
            begin
              nxt[4*n +: 4] = operand_low[4*n +: 4]; // RULE8
            end
          end
          if (f.mask[0])
          begin
            nxt[`SMV_EXC_SUM] = operand_low[`SMV_EXC_SUM]; // RULE11
            nxt[`SMV_OVF]     = operand_low[`SMV_OVF]; // RULE11
            fx_explicit       = 1'b1;
          end
        end
        OP_IMM:
        begin
          sync_op = 1'b1;
          nxt     = imm_word; // RULE12
          if (f.bf == 3'h0)
          begin
            fx_explicit = 1'b1; // RULE11
          end
        end
        OP_BIT_SET:
        begin
          sync_op = 1'b1;
          nxt[f.tgt] = 1'b1; // RULE13
          fx_explicit = (f.tgt == 5'h0);
        end
        OP_BIT_CLR:
        begin
          sync_op = 1'b1;
          nxt[f.tgt] = 1'b0; // RULE14
          fx_explicit = 1'b1;
        end
        OP_ROUND_SINGLE:
        begin
          st_d.rs_valid = 1'b1;
          st_d.rs_path  = rs_path; // RULE15 RULE16 RULE17 RULE18 RULE19
        end
        default:
        begin
          st_d.illegal = 1'b1;
        end
      endcase
      nxt = nxt & ~`SMV_RESERVED_MASK; // RULE5
      // A newly raised exception bit raises the exception summary unless it was written explicitly.
      if (!fx_explicit && ((nxt & ~st_q.fsc & `SMV_EXC_MASK) != 32'h0000_0000))
      begin
        nxt[`SMV_EXC_SUM] = 1'b1;
      end
      vx  = |(nxt & `SMV_INV_MASK);
      enabled_exception_summary = (vx && nxt[`SMV_INV_EN]) || (nxt[`SMV_OVF] && nxt[`SMV_OVF_EN]) ||
            (nxt[`SMV_UNF] && nxt[`SMV_UNF_EN]) || (nxt[`SMV_ZDIV] && nxt[`SMV_ZDIV_EN]) ||
            (nxt[`SMV_INEXACT] && nxt[`SMV_INEXACT_EN]);
      nxt[`SMV_INV_SUM] = vx; // RULE10
      nxt[`SMV_ENA_SUM] = enabled_exception_summary; // RULE10
      if (op != OP_NONE && op != OP_ROUND_SINGLE)
      begin
        st_d.fsc = nxt;
        // Field one is left undefined when recording to another field; it takes the record here.
        if (f.record && !(op == OP_TO_COND && f.bf == 3'h1))
        begin
          if (op == OP_READ)
          begin
            cr_new[4:7] = {st_q.fsc[0], st_q.fsc[1], st_q.fsc[2], st_q.fsc[3]}; // RULE3
          end
          else
          begin
            cr_new[4:7] = {nxt[0], nxt[1], nxt[2], nxt[3]}; // RULE3 RULE7
          end
        end
        st_d.cr.we   = f.record || (op == OP_TO_COND); // RULE3
        st_d.cr.data = cr_new;
      end
      if (sync_op)
      begin
        st_d.hold_cnt = SYNC_HOLD; // RULE9
      end
    end
    st_d.hold = (st_d.hold_cnt != 4'h0); // RULE9
  end

  always_ff @(posedge I_MCLK)
  begin
    if (!I_RESET_N)
    begin
      st_q     <= '0;
      st_q.fsc <= `SMV_FSC_RESET; // RULE20
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign O_READY                = !st_q.hold;
  assign O_FP_HOLD              = st_q.hold;
  assign O_DONE                 = st_q.done;
  assign O_ILLEGAL              = st_q.illegal;
  assign O_FR_WRITE             = st_q.fr;
  assign O_CR_WRITE             = st_q.cr;
  assign O_FLOAT_STATUS_CONTROL = st_q.fsc;
  assign O_RS_VALID             = st_q.rs_valid;
  assign O_RS_PATH              = st_q.rs_path;

endmodule
`default_nettype wire

// File: fp_status_move_props.sv
// Concurrent checks on the ports of the floating-point status move unit.
`default_nettype none
`include "status_move_consts.svh"
module fp_status_move_props
  import status_move_pkg::*;
#(
  parameter logic [3:0] SYNC_HOLD = 4'h2
) (
  // Clock and reset.
  input wire logic        I_MCLK,
  input wire logic        I_RESET_N,
  // Issue side.
  input wire logic        I_INSN_VALID,
  input wire logic [0:31] I_INSN,
  input wire logic [0:63] I_OPERAND_B,
  input wire logic [0:31] I_COND_REG,
  // Results.
  input wire logic        O_READY,
  input wire logic        O_FP_HOLD,
  input wire logic        O_DONE,
  input wire logic        O_ILLEGAL,
  input wire fr_write_t   O_FR_WRITE,
  input wire cr_write_t   O_CR_WRITE,
  input wire logic [0:31] O_FLOAT_STATUS_CONTROL,
  input wire logic        O_RS_VALID,
  input wire rs_path_t    O_RS_PATH
);
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_RESET_N);
  logic       taken;
  logic [9:0] xo;
  logic [4:0] bt;
  logic [3:0] hcnt;
  assign taken = I_INSN_VALID && O_READY && (I_INSN[0:5] == `SMV_PRIMARY_FLOAT);
  assign xo    = I_INSN[21:30];
  assign bt    = I_INSN[6:10];
  always_ff @(posedge I_MCLK)
  begin
    if (!I_RESET_N)
      hcnt <= 4'h0;
    else
      hcnt <= O_FP_HOLD ? hcnt + 4'h1 : 4'h0;
  end
  a_read_high: assert property (O_FR_WRITE.we |-> O_FR_WRITE.data[0:31] == `SMV_QNAN_HIGH)
    else $error("read result high half is not all ones");
  a_read_low: assert property (taken && xo == `SMV_XO_READ |=> O_FR_WRITE.we && O_FR_WRITE.idx == $past(bt)
    && O_FR_WRITE.data[32:63] == $past(O_FLOAT_STATUS_CONTROL)) else $error("read result low half wrong");
  a_record_off: assert property (taken && xo != `SMV_XO_TO_COND && !I_INSN[31] |=> !O_CR_WRITE.we)
    else $error("condition written without record flag");
  a_cond_write: assert property (taken && xo == `SMV_XO_TO_COND |=> O_CR_WRITE.we && O_DONE)
    else $error("copy to condition gave no condition write");
  a_sync_hold: assert property (taken && xo inside {`SMV_XO_FIELDS, `SMV_XO_IMM, `SMV_XO_BIT_SET, `SMV_XO_BIT_CLR}
    |=> O_FP_HOLD ##1 O_FP_HOLD) else $error("status write did not hold later operations");
  a_hold_len: assert property ($fell(O_FP_HOLD) |-> hcnt == SYNC_HOLD)
    else $error("hold lasted the wrong number of cycles");
  a_refused_word: assert property (I_INSN_VALID && !O_READY |=> !O_DONE && !O_ILLEGAL)
    else $error("word taken while not ready");
  a_derived_bits: assert property (taken && xo inside {`SMV_XO_BIT_SET, `SMV_XO_BIT_CLR} && bt inside {1, 2}
    |=> $stable(O_FLOAT_STATUS_CONTROL[1:2])) else $error("derived summary bit written directly");
  a_bit_set: assert property (taken && xo == `SMV_XO_BIT_SET && bt >= 3 && bt < 20
    |=> O_FLOAT_STATUS_CONTROL[$past(bt)]) else $error("indexed status bit not set");
  a_bit_clr: assert property (taken && xo == `SMV_XO_BIT_CLR && bt >= 3 && bt < 20
    |=> !O_FLOAT_STATUS_CONTROL[$past(bt)]) else $error("indexed status bit not cleared");
  a_rs_pulse: assert property (taken && xo == `SMV_XO_ROUND_SINGLE |=> O_RS_VALID ##1 !O_RS_VALID)
    else $error("classification strobe wrong");
endmodule
bind fp_status_move_unit fp_status_move_props #(.SYNC_HOLD(SYNC_HOLD)) u_props (
  .I_MCLK(I_MCLK), .I_RESET_N(I_RESET_N), .I_INSN_VALID(I_INSN_VALID), .I_INSN(I_INSN),
  .I_OPERAND_B(I_OPERAND_B), .I_COND_REG(I_COND_REG), .O_READY(O_READY), .O_FP_HOLD(O_FP_HOLD),
  .O_DONE(O_DONE), .O_ILLEGAL(O_ILLEGAL), .O_FR_WRITE(O_FR_WRITE), .O_CR_WRITE(O_CR_WRITE),
  .O_FLOAT_STATUS_CONTROL(O_FLOAT_STATUS_CONTROL), .O_RS_VALID(O_RS_VALID), .O_RS_PATH(O_RS_PATH));
`default_nettype wire

// File: cond_reg_model.sv
// Condition register of the core, fed back to the unit as the issue logic would.
`default_nettype none
module cond_reg_model
  import status_move_pkg::*;
(
  // Clock and reset.
  input  wire logic      i_clk,
  input  wire logic      i_reset_n,
  // Write from the unit and current value.
  input  wire cr_write_t i_cr_write,
  output logic [0:31]    o_cond_reg
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      o_cond_reg <= 32'h0000_0000;
    else if (i_cr_write.we)
      o_cond_reg <= i_cr_write.data;
  end
endmodule
`default_nettype wire

// File: tb.sv
// Self-checking testbench for the floating-point status move unit.
`default_nettype none
`include "status_move_consts.svh"
module tb
  import status_move_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk;
  logic        reset_n;
  logic        valid;
  logic [0:31] insn;
  logic [0:63] opb;
  logic [0:31] cond;
  logic        ready;
  logic        hold;
  logic        done;
  logic        illegal;
  fr_write_t   frw;
  cr_write_t   crw;
  logic [0:31] fsc;
  logic        rs_valid;
  rs_path_t    rs_path;
  int          failures;
  int          n_checks;
  int          cyc;

  fp_status_move_unit uut (.I_MCLK(mclk), .I_RESET_N(reset_n), .I_INSN_VALID(valid), .I_INSN(insn),
    .I_OPERAND_B(opb), .I_COND_REG(cond), .O_READY(ready), .O_FP_HOLD(hold), .O_DONE(done),
    .O_ILLEGAL(illegal), .O_FR_WRITE(frw), .O_CR_WRITE(crw), .O_FLOAT_STATUS_CONTROL(fsc),
    .O_RS_VALID(rs_valid), .O_RS_PATH(rs_path));
  cond_reg_model u_cr (.i_clk(mclk), .i_reset_n(reset_n), .i_cr_write(crw), .o_cond_reg(cond));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic print_verdict();
    $display("checks %0d, failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      failures++;
      print_verdict();
    end
  end

  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  function automatic logic [0:31] mk(input logic [9:0] xo, input logic [4:0] a, input logic [4:0] b,
                                     input logic [4:0] c, input logic rc);
    return {`SMV_PRIMARY_FLOAT, a, b, c, xo, rc};
  endfunction

  // Presents one word, keeps it up until the unit is ready, and returns just after the answer edge.
  task automatic issue(input logic [0:31] w, input logic [0:63] b);
    int n;
    @(posedge mclk);
    #1;
    valid = 1'b1;
    insn  = w;
    opb   = b;
    n     = 0;
    while (!ready && n < 20)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk("ready", ready, 64'h0000_0000_0000_0001);
    @(posedge mclk);
    #1;
    valid = 1'b0;
  endtask

  task automatic t_imm();
    issue(mk(`SMV_XO_IMM, 5'h18, 5'h00, 5'h14, 1'b0), 64'h0000_0000_0000_0000);
    chk("hold", hold, 64'h0000_0000_0000_0001);
    chk("ready", ready, 64'h0000_0000_0000_0000);
    chk("status", fsc, 64'h0000_0000_0000_00A0);
    issue(mk(`SMV_XO_IMM, 5'h00, 5'h00, 5'h12, 1'b1), 64'h0000_0000_0000_0000);
    chk("status", fsc, 64'h0000_0000_9000_00A0);
    chk("cr we", crw.we, 64'h0000_0000_0000_0001);
    chk("cr", crw.data, 64'h0000_0000_0900_0000);
  endtask

  task automatic t_bits();
    issue(mk(`SMV_XO_BIT_SET, 5'h05, 5'h00, 5'h00, 1'b0), 64'h0000_0000_0000_0000);
    chk("status", fsc, 64'h0000_0000_9400_00A0);
    issue(mk(`SMV_XO_BIT_CLR, 5'h05, 5'h00, 5'h00, 1'b0), 64'h0000_0000_0000_0000);
    chk("status", fsc, 64'h0000_0000_9000_00A0);
    issue(mk(`SMV_XO_BIT_SET, 5'h01, 5'h00, 5'h00, 1'b0), 64'h0000_0000_0000_0000);
    chk("status", fsc, 64'h0000_0000_9000_00A0);
  endtask

  task automatic t_cond();
    issue(mk(`SMV_XO_TO_COND, 5'h0C, 5'h00, 5'h00, 1'b0), 64'h0000_0000_0000_0000);
    chk("cr", crw.data, 64'h0000_0000_0909_0000);
    chk("status", fsc, 64'h0000_0000_0000_00A0);
    issue(mk(`SMV_XO_TO_COND, 5'h1C, 5'h18, 5'h00, 1'b0), 64'h0000_0000_0000_0000);
    chk("cr", crw.data, 64'h0000_0000_0909_000A);
    issue(mk(`SMV_XO_TO_COND, 5'h0C, 5'h14, 5'h00, 1'b0), 64'h0000_0000_0000_0000);
    chk("cr", crw.data, 64'h0000_0000_0900_000A);
  endtask

  task automatic t_read();
    issue(mk(`SMV_XO_READ, 5'h07, 5'h00, 5'h00, 1'b1), 64'h0000_0000_0000_0000);
    chk("fr we", frw.we, 64'h0000_0000_0000_0001);
    chk("fr idx", frw.idx, 64'h0000_0000_0000_0007);
    chk("fr data", frw.data, 64'hFFFF_FFFF_0000_00A0);
    chk("cr", crw.data, 64'h0000_0000_0000_000A);
  endtask

  task automatic t_mask();
    issue(mk(`SMV_XO_FIELDS, 5'h08, 5'h02, 5'h00, 1'b0), 64'h0000_0000_8000_0008);
    chk("status", fsc, 64'h0000_0000_8000_00A8);
    chk("hold", hold, 64'h0000_0000_0000_0001);
  endtask

  task automatic t_round();
    logic [0:63] ops [10];
    rs_path_t    exps [10];
    ops  = '{64'h3800_0000_0000_0001, 64'h3810_0000_0000_0000, 64'h47E0_0000_0000_0000,
             64'h47F0_0000_0000_0000, 64'h7FE0_0000_0000_0000, 64'h8000_0000_0000_0000,
             64'h7FF0_0000_0000_0000, 64'h7FF8_0000_0000_0000, 64'h7FF4_0000_0000_0000,
             64'h0000_0000_0000_0001};
    exps = '{RS_UNDERFLOW_ENABLED, RS_NORMAL, RS_NORMAL, RS_OVERFLOW_DISABLED, RS_OVERFLOW_DISABLED,
             RS_ZERO, RS_INFINITY, RS_QUIET_NAN, RS_SIGNALING_NAN, RS_UNDERFLOW_DISABLED};
    for (int k = 0; k < 10; k++)
    begin
      if (k == 9)
        issue(mk(`SMV_XO_BIT_CLR, 5'h1A, 5'h00, 5'h00, 1'b0), 64'h0000_0000_0000_0000);
      issue(mk(`SMV_XO_ROUND_SINGLE, 5'h01, 5'h00, 5'h00, 1'b0), ops[k]);
      chk("rs valid", rs_valid, 64'h0000_0000_0000_0001);
      chk("rs path", 64'(rs_path), 64'(exps[k]));
    end
  endtask

  task automatic t_illegal();
    issue(32'h0000_0000, 64'h0000_0000_0000_0000);
    chk("illegal", illegal, 64'h0000_0000_0000_0001);
    chk("done", done, 64'h0000_0000_0000_0000);
    chk("status", fsc, 64'h0000_0000_8000_0088);
  endtask

  // Raises flags in fields one and three, then copies each field out and checks that it is cleared.
  task automatic t_clear();
    issue(mk(`SMV_XO_BIT_SET, 5'h04, 5'h00, 5'h00, 1'b0), 64'h0000_0000_0000_0000);
    chk("status", fsc, 64'h0000_0000_8800_0088);
    issue(mk(`SMV_XO_TO_COND, 5'h00, 5'h04, 5'h00, 1'b0), 64'h0000_0000_0000_0000);
    chk("cr", crw.data, 64'h0000_0000_8000_000A);
    chk("status", fsc, 64'h0000_0000_8000_0088);
    issue(mk(`SMV_XO_BIT_SET, 5'h0C, 5'h00, 5'h00, 1'b0), 64'h0000_0000_0000_0000);
    chk("status", fsc, 64'h0000_0000_E008_0088);
    issue(mk(`SMV_XO_TO_COND, 5'h08, 5'h0C, 5'h00, 1'b0), 64'h0000_0000_0000_0000);
    chk("cr", crw.data, 64'h0000_0000_8080_000A);
    chk("status", fsc, 64'h0000_0000_8000_0088);
  endtask

  initial
  begin
    failures = 0;
    n_checks = 0;
    cyc      = 0;
    reset_n  = 1'b0;
    valid    = 1'b0;
    insn     = 32'h0000_0000;
    opb      = 64'h0000_0000_0000_0000;
    repeat (10) @(posedge mclk);
    #1;
    reset_n = 1'b1;
    chk("status", fsc, 64'h0000_0000_0000_0000);
    t_imm();
    t_bits();
    t_cond();
    t_read();
    t_mask();
    t_round();
    t_illegal();
    t_clear();
    print_verdict();
  end
endmodule
`default_nettype wire
